// *** rtl/wake_io_map.svh ***
`ifndef WAKE_IO_MAP_SVH
`define WAKE_IO_MAP_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_CTRL 8'h00
`define OFS_ARM 8'h04
`define OFS_STATUS 8'h08
`define OFS_DIR_A 8'h0c
`define OFS_DIR_B 8'h10
`define OFS_DIR_C 8'h14
`define OFS_OUT_A 8'h18
`define OFS_OUT_B 8'h1c
`define OFS_OUT_C 8'h20
`define OFS_IN_A 8'h24
`define OFS_IN_B 8'h28
`define OFS_IN_C 8'h2c

// ----------------------------------------
// field positions
// ----------------------------------------
`define CTRL_SEF_A 0
`define CTRL_SEF_C 1
`define CTRL_STOP_RELEASE_ENABLE_SIX 2
`define CTRL_PORT_INTERRUPT_ENABLE_ZERO 3
`define CTRL_TAP_LO 4
`define ARM_BIT 0
`define ST_FLAG_A 0
`define ST_FLAG_C 1
`define ST_HALT_RELEASE_REQUEST_ZERO 2
`define ST_FLAG_D 3
`define ST_HALT_OK 4
`define ST_STOP_OK 5
`define DIR_C_PDSEL 4

// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define NIB_RST 4'h0
`define PDSEL_RST 1'b0
`define CLK_KHZ 40000
`define FILT_SLOW_MS 32
`define FILT_MID_MS 8
`define FILT_FAST_MS 2
`define PRESC_W 21

`endif

// *** rtl/wake_io_pkg.sv ***
package wake_io_pkg;

	// ----------------------------------------
	// filter clock tap select
	// ----------------------------------------
	typedef enum logic [1:0] {
		tap_slow = 2'b00,
		tap_mid = 2'b01,
		tap_fast = 2'b10
	} filter_tap_type;

	// ----------------------------------------
	// whole state of the port block
	// ----------------------------------------
	typedef struct packed {
		logic [2:0][3:0] sync1;
		logic [2:0][3:0] sync2;
		logic [2:0][3:0] sync3;
		logic [2:0][3:0] clean;
		logic [2:0][3:0] dir;
		logic [2:0][3:0] outr;
		logic pdsel;
		logic [1:0] sef;
		logic stop_release_enable_six;
		logic port_interrupt_enable_zero;
		logic [1:0] tap;
		logic [1:0] flag;
		logic halt_release_request_zero;
		logic [20:0] presc;
		logic [1:0] filt;
		logic [1:0] pend;
		logic [1:0] lvl_prev;
		logic stop_wake;
		logic stop_rel;
		logic ret_stop;
		logic arm_pulse;
		logic [31:0] rdata;
		logic rerr;
	} state_type;

endpackage

// *** rtl/wake_io_ports.sv ***
// Chosen here: the address map and register access over APB.
`include "wake_io_map.svh"

// What this block does
// - filtered mode, port a enabled: either edge of filtered OR sets its flag
// - a set start flag blocks further detection until the arm command
// - arm command clears port a and c start flags together and pulses the arm output
// - port a start flag setting also sets halt release request zero
// - level mode: halt entry only with inputs low; rising input wakes
// - filtered mode: halt entry always allowed; filtered change wakes
// - with interrupt enable zero, port a flag raises an interrupt request
// - stop entry only with ports a and c low; level mode port a rise gives stop release
// - filtered stop release needs switch enable and stop release enable six
// - after filtered stop release the filter keeps running until flag sets
// - input falling before flag sets sends the device back to stop
// - each pin has its own direction; all inputs after reset
// - output command loads output register; output pins drive it
// - input read: pin level for inputs, output register for outputs
// - input pins have a pull-down enabled by a build option
// - port c: direction bit4 set enables pull-down, clear enables hold
// - port c level mode, enable set: rising OR sets port c flag
// - four inputs of a port are ORed before detection
// - port a level mode, enable set: rising OR sets port a flag
// - filter clock selects 32, 8 or 2 ms taps, slowest by default
module wake_io_ports #(
	parameter bit PORT_A_FILTERED = 1'b1,
	parameter bit PORT_C_FILTERED = 1'b1,
	parameter bit [2:0] PULLDOWN_EN = 3'h7,
	parameter bit HOLD_EN_C = 1'b1,
	parameter int unsigned SLOW_CYC = `FILT_SLOW_MS * `CLK_KHZ,
	parameter int unsigned MID_CYC = `FILT_MID_MS * `CLK_KHZ,
	parameter int unsigned FAST_CYC = `FILT_FAST_MS * `CLK_KHZ
) (
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic ce_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic [3:0] port_a_i,
	output logic [3:0] port_a_o,
	output logic [3:0] port_a_oe_o,
	output logic [3:0] port_a_pulldown_o,
	input wire logic [3:0] port_b_i,
	output logic [3:0] port_b_o,
	output logic [3:0] port_b_oe_o,
	output logic [3:0] port_b_pulldown_o,
	input wire logic [3:0] port_c_i,
	output logic [3:0] port_c_o,
	output logic [3:0] port_c_oe_o,
	output logic [3:0] port_c_pulldown_o,
	output logic [3:0] port_c_hold_o,
	input wire logic port_d_start_flag_i,
	input wire logic stop_mode_i,
	output logic port_a_start_flag_o,
	output logic port_c_start_flag_o,
	output logic start_condition_arm_o,
	output logic halt_release_request_zero_o,
	output logic irq_o,
	output logic halt_entry_allowed_o,
	output logic stop_entry_allowed_o,
	output logic stop_release_o,
	output logic return_to_stop_o
);

	// ----------------------------------------
	// state and helpers
	// ----------------------------------------
	wake_io_pkg::state_type q;
	wake_io_pkg::state_type n;
	logic wr;
	logic setup;
	logic arm;
	logic hrf_clr;
	logic tick;
	logic [20:0] lim;
	logic [1:0] orv;
	logic [1:0] filtered;
	logic [1:0] ev;
	logic [1:0] set;
	logic or_a_rise;
	logic [2:0][3:0] rdback;
	logic [31:0] status;

	assign pready_o = ce_i;
	assign setup = psel_i && !penable_i;
	assign wr = psel_i && penable_i && pready_o && pwrite_i;
	assign arm = wr && paddr_i == `OFS_ARM && pwdata_i[`ARM_BIT];
	assign hrf_clr = wr && paddr_i == `OFS_STATUS && pwdata_i[`ST_HALT_RELEASE_REQUEST_ZERO];
	assign filtered = {PORT_C_FILTERED, PORT_A_FILTERED};

	// four inputs ORed before any detection
	assign orv = {|q.clean[2], |q.clean[0]};

	// ----------------------------------------
	// filter clock prescaler
	// ----------------------------------------
	always_comb begin
		unique case (q.tap)
			wake_io_pkg::tap_mid: lim = `PRESC_W'(MID_CYC - 1);
			wake_io_pkg::tap_fast: lim = `PRESC_W'(FAST_CYC - 1);
			default: lim = `PRESC_W'(SLOW_CYC - 1);
		endcase
	end
	assign tick = q.presc >= lim;

	// ----------------------------------------
	// detection events per watched port
	// ----------------------------------------
	always_comb begin
		for (int k = 0; k < 2; k++) begin
			if (filtered[k]) begin
				// either edge of the debounced level
				ev[k] = tick && orv[k] != q.filt[k] && q.pend[k];
			end else begin
				ev[k] = orv[k] && !q.lvl_prev[k];
			end
			// no new detection while the flag stands
			set[k] = ev[k] && q.sef[k] && !q.flag[k];
		end
	end
	assign or_a_rise = orv[0] && !q.lvl_prev[0];

	// read-back mixes pin level and output register
	always_comb begin
		for (int p = 0; p < 3; p++) begin
			rdback[p] = (q.dir[p] & q.outr[p]) | (~q.dir[p] & q.clean[p]);
		end
	end

	always_comb begin
		status = 32'h0000_0000;
		status[`ST_FLAG_A] = q.flag[0];
		status[`ST_FLAG_C] = q.flag[1];
		status[`ST_HALT_RELEASE_REQUEST_ZERO] = q.halt_release_request_zero;
		status[`ST_FLAG_D] = port_d_start_flag_i;
		status[`ST_HALT_OK] = halt_entry_allowed_o;
		status[`ST_STOP_OK] = stop_entry_allowed_o;
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		n = q;
		n.stop_rel = 1'b0;
		n.ret_stop = 1'b0;
		n.arm_pulse = arm;
		// three flop synchroniser, level taken when last two agree
		n.sync1 = {port_c_i, port_b_i, port_a_i};
		n.sync2 = q.sync1;
		n.sync3 = q.sync2;
		for (int p = 0; p < 3; p++) begin
			for (int b = 0; b < 4; b++) begin
				if (q.sync2[p][b] == q.sync3[p][b]) begin
					n.clean[p][b] = q.sync3[p][b];
				end
			end
		end
		n.presc = tick ? `PRESC_W'(0) : q.presc + `PRESC_W'(1);
		n.lvl_prev = orv;
		// filter keeps running in every mode
		for (int k = 0; k < 2; k++) begin
			if (tick) begin
				if (orv[k] != q.filt[k]) begin
					if (q.pend[k]) begin
						n.filt[k] = orv[k];
						n.pend[k] = 1'b0;
					end else begin
						n.pend[k] = 1'b1;
					end
				end else begin
					n.pend[k] = 1'b0;
				end
			end
			// set wins over the arm clear
			n.flag[k] = (q.flag[k] && !arm) || set[k];
		end
		n.halt_release_request_zero = (q.halt_release_request_zero && !hrf_clr) || set[0] || set[1];
		// stop release on rising port a input
		if (stop_mode_i && or_a_rise && q.sef[0]
				&& (!PORT_A_FILTERED || q.stop_release_enable_six)) begin
			n.stop_rel = 1'b1;
			n.stop_wake = PORT_A_FILTERED;
		end else if (q.stop_wake) begin
			if (q.flag[0] || set[0]) begin
				n.stop_wake = 1'b0;
			end else if (!orv[0]) begin
				n.stop_wake = 1'b0;
				n.ret_stop = 1'b1;
			end
		end
		if (wr) begin
			unique case (paddr_i)
				`OFS_CTRL: begin
					n.sef[0] = pwdata_i[`CTRL_SEF_A];
					n.sef[1] = pwdata_i[`CTRL_SEF_C];
					n.stop_release_enable_six = pwdata_i[`CTRL_STOP_RELEASE_ENABLE_SIX];
					n.port_interrupt_enable_zero = pwdata_i[`CTRL_PORT_INTERRUPT_ENABLE_ZERO];
					n.tap = pwdata_i[`CTRL_TAP_LO +: 2];
				end
				`OFS_DIR_A: n.dir[0] = pwdata_i[3:0];
				`OFS_DIR_B: n.dir[1] = pwdata_i[3:0];
				`OFS_DIR_C: begin
					n.dir[2] = pwdata_i[3:0];
					n.pdsel = pwdata_i[`DIR_C_PDSEL];
				end
				`OFS_OUT_A: n.outr[0] = pwdata_i[3:0];
				`OFS_OUT_B: n.outr[1] = pwdata_i[3:0];
				`OFS_OUT_C: n.outr[2] = pwdata_i[3:0];
				default: begin
				end
			endcase
		end
		if (setup) begin
			n.rerr = 1'b0;
			n.rdata = 32'h0000_0000;
			unique case (paddr_i)
				`OFS_CTRL: begin
					n.rdata[`CTRL_SEF_A] = q.sef[0];
					n.rdata[`CTRL_SEF_C] = q.sef[1];
					n.rdata[`CTRL_STOP_RELEASE_ENABLE_SIX] = q.stop_release_enable_six;
					n.rdata[`CTRL_PORT_INTERRUPT_ENABLE_ZERO] = q.port_interrupt_enable_zero;
					n.rdata[`CTRL_TAP_LO +: 2] = q.tap;
				end
				`OFS_ARM: n.rdata = 32'h0000_0000;
				`OFS_STATUS: n.rdata = status;
				`OFS_DIR_A: n.rdata[3:0] = q.dir[0];
				`OFS_DIR_B: n.rdata[3:0] = q.dir[1];
				`OFS_DIR_C: begin
					n.rdata[3:0] = q.dir[2];
					n.rdata[`DIR_C_PDSEL] = q.pdsel;
				end
				`OFS_OUT_A: n.rdata[3:0] = q.outr[0];
				`OFS_OUT_B: n.rdata[3:0] = q.outr[1];
				`OFS_OUT_C: n.rdata[3:0] = q.outr[2];
				`OFS_IN_A: n.rdata[3:0] = rdback[0];
				`OFS_IN_B: n.rdata[3:0] = rdback[1];
				`OFS_IN_C: n.rdata[3:0] = rdback[2];
				default: n.rerr = 1'b1;
			endcase
		end
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			q <= '0;
			q.tap <= wake_io_pkg::tap_slow;
			q.pdsel <= `PDSEL_RST;
		end else if (ce_i) begin
			q <= n;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign prdata_o = q.rdata;
	assign pslverr_o = q.rerr && psel_i && penable_i;
	assign port_a_o = q.outr[0];
	assign port_b_o = q.outr[1];
	assign port_c_o = q.outr[2];
	assign port_a_oe_o = q.dir[0];
	assign port_b_oe_o = q.dir[1];
	assign port_c_oe_o = q.dir[2];
	assign port_a_pulldown_o = ~q.dir[0] & {4{PULLDOWN_EN[0]}};
	assign port_b_pulldown_o = ~q.dir[1] & {4{PULLDOWN_EN[1]}};
	assign port_c_pulldown_o = ~q.dir[2] & {4{PULLDOWN_EN[2]
		&& (!HOLD_EN_C || q.pdsel)}};
	assign port_c_hold_o = ~q.dir[2] & {4{PULLDOWN_EN[2] && HOLD_EN_C
		&& !q.pdsel}};
	assign port_a_start_flag_o = q.flag[0];
	assign port_c_start_flag_o = q.flag[1];
	assign start_condition_arm_o = q.arm_pulse;
	assign halt_release_request_zero_o = q.halt_release_request_zero;
	assign irq_o = q.halt_release_request_zero && q.port_interrupt_enable_zero;
	assign halt_entry_allowed_o = (PORT_A_FILTERED || !orv[0])
		&& (PORT_C_FILTERED || !orv[1]);
	assign stop_entry_allowed_o = !orv[0] && !orv[1];
	assign stop_release_o = q.stop_rel;
	assign return_to_stop_o = q.ret_stop;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (reset_i);

	flag_needs_enable_a: assert property ($rose(q.flag[0]) |->
		$past(q.sef[0])) else $error("port a flag set without enable");
	flag_blocks_a: assert property (q.flag[0] && !(ce_i && arm) |=>
		q.flag[0]) else $error("port a flag dropped without arm");
	hold_c_flag_a: assert property (q.flag[1] && !(ce_i && arm) |=>
		q.flag[1]) else $error("port c flag dropped without arm");
	arm_clears_a: assert property (ce_i && arm && set == 2'b00 |=>
		!q.flag[0] && !q.flag[1] && start_condition_arm_o)
		else $error("arm did not clear flags");
	arm_once_a: assert property (ce_i && !arm &&
		start_condition_arm_o |=> !start_condition_arm_o)
		else $error("arm pulse too long");
	hrf_follows_a: assert property (ce_i && set[0] |=>
		q.halt_release_request_zero && q.flag[0]) else $error("halt request missing");
	hrf_clear_a: assert property (ce_i && hrf_clr && set == 2'b00 |=>
		!q.halt_release_request_zero) else $error("halt request not cleared");
	hrf_from_c_a: assert property (ce_i && set[1] |=>
		q.halt_release_request_zero && q.flag[1]) else $error("port c halt request missing");
	irq_raise_a: assert property ($rose(q.flag[0]) && q.port_interrupt_enable_zero |->
		irq_o) else $error("interrupt not raised");
	irq_low_a: assert property (!q.port_interrupt_enable_zero |-> !irq_o)
		else $error("interrupt without enable");
	halt_block_a: assert property (!PORT_C_FILTERED && orv[1] |->
		!halt_entry_allowed_o) else $error("halt allowed high");
	halt_free_a: assert property (PORT_A_FILTERED && (PORT_C_FILTERED
		|| !orv[1]) |-> halt_entry_allowed_o)
		else $error("filtered halt entry refused");
	stop_block_a: assert property (orv[0] |-> !stop_entry_allowed_o)
		else $error("stop allowed with port a high");
	stop_cond_a: assert property (stop_release_o |->
		$past(q.sef[0]) && (!PORT_A_FILTERED || $past(q.stop_release_enable_six)))
		else $error("stop release without enables");
	stop_halt_a: assert property (stop_release_o |->
		q.stop_wake == PORT_A_FILTERED)
		else $error("filtered stop release not held in halt");
	stop_back_a: assert property ($rose(return_to_stop_o) |->
		!$past(orv[0]) && !$past(q.flag[0]))
		else $error("return to stop with input high");
	dir_reset_a: assert property ($past(reset_i) |-> q.dir == '0)
		else $error("pins not inputs after reset");
	dir_write_a: assert property (ce_i && wr
		&& paddr_i == `OFS_DIR_B |=> port_b_oe_o == $past(pwdata_i[3:0]))
		else $error("direction write lost");
	out_write_a: assert property (wr && paddr_i == `OFS_OUT_B
		|=> port_b_o == $past(pwdata_i[3:0]))
		else $error("output write lost");
	a_pull_in_a: assert property ((port_a_oe_o
		& port_a_pulldown_o) == 4'h0) else $error("pull-down on output pin");
	b_pull_in_a: assert property ((port_b_oe_o
		& port_b_pulldown_o) == 4'h0) else $error("pull-down on output pin");
	pull_hold_a: assert property ((port_c_hold_o
		& port_c_pulldown_o) == 4'h0) else $error("pull-down and hold both on");
	level_c_a: assert property (!PORT_C_FILTERED && ce_i && q.sef[1]
		&& !q.flag[1] && orv[1] && !q.lvl_prev[1] |=> q.flag[1])
		else $error("port c level rise missed");
	tap_reset_a: assert property ($past(reset_i) |->
		q.tap == wake_io_pkg::tap_slow) else $error("filter tap not slow");
	filter_two_a: assert property ($changed(q.filt[0]) |->
		$past(q.pend[0]) && $past(tick)) else $error("filter too fast");
	read_mix_a: assert property (ce_i && setup
		&& paddr_i == `OFS_IN_A |=> prdata_o[3:0] == $past(rdback[0]))
		else $error("bad read");
	ce_freeze_a: assert property (!ce_i |=> q == $past(q))
		else $error("state moved while clock enable low");

	flag_set_c: cover property ($rose(q.flag[0]));
	stop_back_c: cover property ($rose(q.ret_stop));
	arm_c: cover property (ce_i && arm && q.flag[0]);
	irq_c: cover property ($rose(irq_o));
	stop_rel_c: cover property ($rose(stop_release_o));

endmodule

// *** tb/switch_pad_model.sv ***
module switch_pad_model (
	input wire logic core_clk_i,
	input wire logic [11:0] closed_i,
	input wire logic [11:0] level_i,
	input wire logic [11:0] oe_i,
	input wire logic [11:0] drive_i,
	input wire logic [11:0] pull_i,
	output logic [11:0] pin_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [11:0] float_q = 12'h5a5;

	// ----------------------------------------
	// pad level: driver, switch, pull or float
	// ----------------------------------------
	always @(posedge core_clk_i) float_q <= ~float_q;

	always_comb begin
		for (int k = 0; k < 12; k++) begin
			if (oe_i[k]) pin_o[k] = drive_i[k];
			else if (closed_i[k]) pin_o[k] = level_i[k];
			else if (pull_i[k]) pin_o[k] = 1'b0;
			else pin_o[k] = float_q[k];
		end
	end
endmodule

// *** tb/wake_capable_io_ports_bench.sv ***
`include "wake_io_map.svh"

module wake_capable_io_ports_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk_i, reset_i, ce_i, psel_i, penable_i, pwrite_i, stop_m;
	logic pslverr, pready, flag_a, flag_c, arm_p, halt_release_request_zero, irq, flag_d;
	logic halt_ok, stop_ok, stop_rel, ret_stop, slv_err;
	logic [7:0] paddr_i;
	logic [31:0] pwdata_i, prdata, rd;
	logic [3:0] pa_o, pa_oe, pa_pd, pb_o, pb_oe, pb_pd;
	logic [3:0] pc_o, pc_oe, pc_pd, pc_hold;
	logic [11:0] closed, level, pins;
	int fails, samples_checked;

	wake_io_ports #(.PORT_C_FILTERED(1'b0), .SLOW_CYC(8), .MID_CYC(4),
		.FAST_CYC(2)) wake_io_ports_i (
		.core_clk_i(core_clk_i), .reset_i(reset_i), .ce_i(ce_i),
		.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
		.paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr),
		.port_a_i(pins[3:0]), .port_a_o(pa_o), .port_a_oe_o(pa_oe),
		.port_a_pulldown_o(pa_pd), .port_b_i(pins[7:4]), .port_b_o(pb_o),
		.port_b_oe_o(pb_oe), .port_b_pulldown_o(pb_pd),
		.port_c_i(pins[11:8]), .port_c_o(pc_o), .port_c_oe_o(pc_oe),
		.port_c_pulldown_o(pc_pd), .port_c_hold_o(pc_hold),
		.port_d_start_flag_i(flag_d), .stop_mode_i(stop_m),
		.port_a_start_flag_o(flag_a), .port_c_start_flag_o(flag_c),
		.start_condition_arm_o(arm_p), .halt_release_request_zero_o(halt_release_request_zero),
		.irq_o(irq), .halt_entry_allowed_o(halt_ok),
		.stop_entry_allowed_o(stop_ok), .stop_release_o(stop_rel),
		.return_to_stop_o(ret_stop));

	switch_pad_model switch_pad_model_i (.core_clk_i(core_clk_i),
		.closed_i(closed), .level_i(level),
		.oe_i({pc_oe, pb_oe, pa_oe}), .drive_i({pc_o, pb_o, pa_o}),
		.pull_i({pc_pd | pc_hold, pb_pd, pa_pd}), .pin_o(pins));

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
		input string what);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("FAIL %0t %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge core_clk_i);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge core_clk_i);
		penable_i <= 1'b1;
		@(posedge core_clk_i);
		while (pready !== 1'b1) @(posedge core_clk_i);
		rd = prdata;
		slv_err = pslverr;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask

	task automatic expect_ev(input int sel, input int lim, input string what);
		logic hit;
		hit = 1'b0;
		for (int n = 0; n < lim && !hit; n++) begin
			@(posedge core_clk_i);
			case (sel)
			0: hit = flag_a;
			1: hit = flag_c;
			2: hit = arm_p;
			3: hit = stop_rel;
			default: hit = ret_stop;
			endcase
		end
		chk({31'h0, hit}, 32'h1, what);
	endtask

	task automatic test_done();
		$display("checks %0d fails %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		chk({20'h0, pa_oe, pb_oe, pc_oe}, 32'h0, "dir after reset");
		chk({16'h0, pa_o, pc_o, pa_pd, pb_pd}, 32'h00ff, "outs at reset");
		chk({24'h0, pc_pd, pc_hold}, 32'h0f, "port c hold at reset");
		apb(1'b0, `OFS_CTRL, 32'h0);
		chk(rd, 32'h0, "ctrl reset, slow tap");
		apb(1'b0, 8'h40, 32'h0);
		chk({31'h0, slv_err}, 32'h1, "unmapped access");
		$display("test reset done");
	endtask

	task automatic t_io();
		apb(1'b1, `OFS_OUT_B, 32'h5);
		apb(1'b1, `OFS_DIR_B, 32'h3);
		closed <= 12'h080;
		level <= 12'h080;
		repeat (6) @(posedge core_clk_i);
		chk({pb_oe, pb_o, pb_pd, pins[7:4]}, 32'h35c9, "port b");
		apb(1'b0, `OFS_IN_B, 32'h0);
		chk(rd, 32'h9, "port b read");
		ce_i <= 1'b0;
		closed <= 12'h0;
		repeat (6) @(posedge core_clk_i);
		ce_i <= 1'b1;
		apb(1'b0, `OFS_IN_B, 32'h0);
		chk(rd, 32'h9, "pins frozen while disabled");
		repeat (4) @(posedge core_clk_i);
		apb(1'b0, `OFS_IN_B, 32'h0);
		chk(rd, 32'h1, "pins resume after enable");
		$display("test port io done");
	endtask

	task automatic t_pull();
		apb(1'b1, `OFS_DIR_C, 32'h10);
		@(posedge core_clk_i);
		chk({24'h0, pc_pd, pc_hold}, 32'hf0, "pull-down on");
		apb(1'b1, `OFS_DIR_C, 32'h0);
		@(posedge core_clk_i);
		chk({24'h0, pc_pd, pc_hold}, 32'h0f, "hold on");
		$display("test pull select done");
	endtask

	task automatic t_level_c();
		apb(1'b1, `OFS_CTRL, 32'h2);
		closed <= 12'h400;
		level <= 12'h400;
		expect_ev(1, 20, "port c flag on rise");
		@(posedge core_clk_i);
		chk({29'h0, halt_release_request_zero, halt_ok, stop_ok}, 32'h4, "entry blocked");
		flag_d <= 1'b1;
		apb(1'b0, `OFS_STATUS, 32'h0);
		chk(rd, 32'h0e, "status flags");
		flag_d <= 1'b0;
		apb(1'b1, `OFS_ARM, 32'h1);
		expect_ev(2, 4, "arm pulse");
		chk({31'h0, flag_c}, 32'h0, "arm clears flag");
		closed <= 12'h500;
		level <= 12'h500;
		repeat (10) @(posedge core_clk_i);
		chk({31'h0, flag_c}, 32'h0, "or already high");
		closed <= 12'h0;
		repeat (6) @(posedge core_clk_i);
		chk({30'h0, halt_ok, stop_ok}, 32'h3, "entry allowed");
		apb(1'b1, `OFS_STATUS, 32'h4);
		$display("test level port c done");
	endtask

	task automatic t_filt_a();
		apb(1'b1, `OFS_CTRL, 32'h2d);
		stop_m <= 1'b1;
		closed <= 12'h002;
		level <= 12'h002;
		expect_ev(3, 20, "stop release");
		chk({29'h0, halt_ok, stop_ok, flag_a}, 32'h4, "halt ok");
		expect_ev(0, 40, "flag on rise");
		stop_m <= 1'b0;
		@(posedge core_clk_i);
		chk({30'h0, halt_release_request_zero, irq}, 32'h3, "halt request, irq");
		apb(1'b1, `OFS_STATUS, 32'h4);
		apb(1'b1, `OFS_ARM, 32'h1);
		closed <= 12'h0;
		expect_ev(0, 40, "flag on fall");
		apb(1'b1, `OFS_STATUS, 32'h4);
		apb(1'b1, `OFS_ARM, 32'h1);
		chk({31'h0, irq}, 32'h0, "irq cleared");
		stop_m <= 1'b1;
		closed <= 12'h002;
		repeat (2) @(posedge core_clk_i);
		closed <= 12'h0;
		expect_ev(3, 20, "stop release on glitch");
		expect_ev(4, 20, "back to stop");
		repeat (20) @(posedge core_clk_i);
		chk({31'h0, flag_a}, 32'h0, "glitch rejected");
		stop_m <= 1'b0;
		$display("test filtered port a done");
	endtask

	initial begin
		core_clk_i = 1'b0;
		forever #12.5 core_clk_i = ~core_clk_i;
	end

	initial begin
		reset_i = 1'b1;
		ce_i = 1'b1;
		psel_i = 1'b0;
		penable_i = 1'b0;
		pwrite_i = 1'b0;
		paddr_i = 8'h00;
		pwdata_i = 32'h0;
		stop_m = 1'b0;
		flag_d = 1'b0;
		closed = 12'h0;
		level = 12'h0;
		fails = 0;
		samples_checked = 0;
		repeat (4) @(posedge core_clk_i);
		reset_i <= 1'b0;
		t_reset();
		t_io();
		t_pull();
		t_level_c();
		t_filt_a();
		test_done();
	end

	// the scenarios need well under a thousand cycles
	initial begin
		#(25 * 5000);
		fails++;
		test_done();
	end
endmodule
